// ===== serial_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
  // serial pins
  output var logic sclk_o,
  output var logic sdata_o,
  output var logic load_strobe_o
);
  initial {sclk_o, sdata_o, load_strobe_o} = 3'h0;
  // clock idles low between frames
  task automatic send(input logic [23:0] w);
    for (int i = 23; i >= 0; i--) begin
      sdata_o = w[i];
      #200 sclk_o = 1'b1;
      #200 sclk_o = 1'b0;
    end
    #200 load_strobe_o = 1'b1;
    #400 load_strobe_o = 1'b0;
    sdata_o = ~w[0]; // line driven to the inverse of the last bit, so no stale bit shows
  endtask
endmodule
`default_nettype wire

// ===== synth_port_map.vh
`ifndef SYNTH_PORT_MAP_VH
`define SYNTH_PORT_MAP_VH
`define WORD_W          24
`define WORD_RST        24'h000000
`define CFG_OUTSEL_BIT  0
`define CFG_OSCEN_BIT   1
`define CFG_FSMODE_BIT  2
`define CFG_FSLEVEL_BIT 3
`define CFG_FSHIZ_BIT   4
`define CFG_FASTLK_BIT  5
`define CFG_TSTDIV_BIT  6
`define TSTDIV_W        4
`define TSTDIV_RST      4'h0
`define TSTDIV_ONE      4'h1
`define SYNC_W          8
`define SYNC_RST        8'h00
`define SYNC_SCLK       0
`define SYNC_SDAT       1
`define SYNC_STB        2
`define SYNC_CE         3
`define SYNC_RBE        4
`define SYNC_REF        5
`define SYNC_LOCK       6
`define SYNC_FSA        7
`define BIT_RST         1'h0
`define PIN_DRIVE       1'h0
`define PIN_RELEASE     1'h1
`endif

// ===== synth_serial_load_port.v
// Behaviour
// - each rising serial clock edge shifts the data bit into a 24-bit register
// - rising load strobe copies the shift register into the configuration latch
// - reference buffer enable high forces the reference output on, overriding all
// - fast-settle pin is fast-settle control or a programmed level or high-z output
// - test/lock pin carries test frequency or lock detect, per configuration
// - one shifted and latched word is enough for a frequency change
`timescale 1ns/1ps
`default_nettype none
`include "synth_port_map.vh"
module synth_serial_load_port (
  // clock and reset
  input  wire                  clk_i,
  input  wire                  rstn_i,
  // serial pins
  input  wire                  sclk_i,
  input  wire                  sdata_i,
  input  wire                  load_strobe_i,
  // control pins
  input  wire                  chip_enable_i,
  input  wire                  ref_buffer_enable_i,
  // from the synthesizer core
  input  wire                  ref_clk_i,
  input  wire                  lock_detect_i,
  input  wire                  fast_settle_active_i,
  // outputs
  output reg  [`WORD_W-1:0]    config_word_o,
  output reg                   word_loaded_o,
  output reg                   core_enable_o,
  output reg                   ref_buffer_output_o,
  output reg                   fast_settle_output_o,
  output reg                   fast_settle_output_oe_n_o,
  output reg                   test_lock_output_o
);
  // two-flop synchronisers; first stage read only by second
  reg  [`SYNC_W-1:0]   sync1_q;
  reg  [`SYNC_W-1:0]   sync2_q;

  // edge history and the delayed load pulse
  reg                  sclk_prev_q;
  reg                  stb_prev_q;
  reg                  ref_prev_q;
  reg                  load_q;

  // shift register and test divider
  reg  [`WORD_W-1:0]   shift_q;
  reg  [`WORD_W-1:0]   shift_d;
  reg  [`TSTDIV_W-1:0] tdiv_q;
  reg  [`TSTDIV_W-1:0] tdiv_d;
  reg                  ttog_q;
  reg                  ttog_d;

  // next values of the pin outputs
  reg                  ref_out_d;
  reg                  fs_out_d;
  reg                  fs_oe_n_d;
  reg                  tl_out_d;
  wire [`WORD_W-1:0]   latched;
  wire [`TSTDIV_W-1:0] tdiv_ratio;
  wire                 sclk_s;
  wire                 sdat_s;
  wire                 stb_s;
  wire                 ce_s;
  wire                 rbe_s;
  wire                 ref_s;
  wire                 lock_s;
  wire                 fsa_s;
  wire                 sclk_rise;
  wire                 stb_rise;
  wire                 ref_rise;

  // low-to-high step of a synchronised level
  function rise_of;
    input cur;
    input prev;
    begin
      rise_of = cur & ~prev;
    end
  endfunction

  assign sclk_s     = sync2_q[`SYNC_SCLK];
  assign sdat_s     = sync2_q[`SYNC_SDAT];
  assign stb_s      = sync2_q[`SYNC_STB];
  assign ce_s       = sync2_q[`SYNC_CE];
  assign rbe_s      = sync2_q[`SYNC_RBE];
  assign ref_s      = sync2_q[`SYNC_REF];
  assign lock_s     = sync2_q[`SYNC_LOCK];
  assign fsa_s      = sync2_q[`SYNC_FSA];
  assign sclk_rise  = rise_of(sclk_s, sclk_prev_q);
  assign stb_rise   = rise_of(stb_s, stb_prev_q);
  assign ref_rise   = rise_of(ref_s, ref_prev_q);
  assign tdiv_ratio = latched[`CFG_TSTDIV_BIT+`TSTDIV_W-1:`CFG_TSTDIV_BIT];

  // core levels are sampled too: they are not timed to this clock
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync1_q <= `SYNC_RST;
      sync2_q <= `SYNC_RST;
    end else begin
      sync1_q <= {fast_settle_active_i, lock_detect_i, ref_clk_i, ref_buffer_enable_i,
                  chip_enable_i, load_strobe_i, sdata_i, sclk_i};
      sync2_q <= sync1_q;
    end
  end

  // load pulse delayed one cycle so it meets the word at the outputs
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sclk_prev_q <= `BIT_RST;
      stb_prev_q  <= `BIT_RST;
      ref_prev_q  <= `BIT_RST;
      load_q      <= `BIT_RST;
    end else begin
      sclk_prev_q <= sclk_s;
      stb_prev_q  <= stb_s;
      ref_prev_q  <= ref_s;
      load_q      <= stb_rise;
    end
  end

  // data synchronised with clock, so edge and bit stay aligned
  always @* begin
    shift_d = shift_q;
    if (sclk_rise) begin
      shift_d = {shift_q[`WORD_W-2:0], sdat_s};
    end
  end

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      shift_q <= `WORD_RST;
    end else begin
      shift_q <= shift_d;
    end
  end

  // a single strobe commits a whole word, no multi-word sequence
  word_latch u_latch (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .load_i (stb_rise),
    .word_i (shift_q),
    .word_o (latched)
  );

  // a new ratio below the running count takes effect only after overflow
  always @* begin
    tdiv_d = tdiv_q;
    ttog_d = ttog_q;
    if (ref_rise) begin
      if (tdiv_q == tdiv_ratio) begin
        tdiv_d = `TSTDIV_RST;
        ttog_d = ~ttog_q;
      end else begin
        tdiv_d = tdiv_q + `TSTDIV_ONE;
      end
    end
  end

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tdiv_q <= `TSTDIV_RST;
      ttog_q <= `BIT_RST;
    end else begin
      tdiv_q <= tdiv_d;
      ttog_q <= ttog_d;
    end
  end

  // enable pin wins over chip enable and the config bit
  always @* begin
    if (rbe_s) begin
      ref_out_d = ref_s;
    end else if (ce_s && latched[`CFG_OSCEN_BIT]) begin
      ref_out_d = ref_s;
    end else begin
      ref_out_d = `BIT_RST;
    end
  end

  // general mode: programmed level or released pin
  always @* begin
    if (latched[`CFG_FSMODE_BIT]) begin
      fs_out_d  = latched[`CFG_FSLEVEL_BIT];
      fs_oe_n_d = latched[`CFG_FSHIZ_BIT];
    end else begin
      fs_out_d  = fsa_s & latched[`CFG_FASTLK_BIT];
      fs_oe_n_d = `PIN_DRIVE;
    end
  end

  // shared pin: divided reference or lock indication
  always @* begin
    if (latched[`CFG_OUTSEL_BIT]) begin
      tl_out_d = ttog_q;
    end else begin
      tl_out_d = lock_s;
    end
  end

  // word and its load pulse leave together
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      config_word_o             <= `WORD_RST;
      word_loaded_o             <= `BIT_RST;
      core_enable_o             <= `BIT_RST;
      ref_buffer_output_o       <= `BIT_RST;
      fast_settle_output_o      <= `BIT_RST;
      fast_settle_output_oe_n_o <= `PIN_RELEASE;
      test_lock_output_o        <= `BIT_RST;
    end else begin
      config_word_o             <= latched;
      word_loaded_o             <= load_q;
      core_enable_o             <= ce_s;
      ref_buffer_output_o       <= ref_out_d;
      fast_settle_output_o      <= fs_out_d;
      fast_settle_output_oe_n_o <= fs_oe_n_d;
      test_lock_output_o        <= tl_out_d;
    end
  end
endmodule
`default_nettype wire

// ===== synth_serial_load_port_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "synth_port_map.vh"
module synth_port_checker (
  // watched ports
  input wire logic               clk_i,
  input wire logic               rstn_i,
  input wire logic               load_strobe_i,
  input wire logic               lock_detect_i,
  input wire logic [`WORD_W-1:0] config_word_o,
  input wire logic               word_loaded_o,
  input wire logic               fast_settle_output_o,
  input wire logic               fast_settle_output_oe_n_o,
  input wire logic               test_lock_output_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  a_strobe_loads_word: assert property ($rose(load_strobe_i) |-> ##[3:6] word_loaded_o)
    else $error("strobe rise gave no load");
  a_load_one_pulse: assert property (word_loaded_o |=> !word_loaded_o)
    else $error("load pulse too long");
  a_word_moves_on_load: assert property ($changed(config_word_o) |-> word_loaded_o)
    else $error("word changed without load");
  a_fs_pin_hiz: assert property ((config_word_o[2] && config_word_o[4]) [*4]
    |-> fast_settle_output_oe_n_o) else $error("pin not released");
  a_fs_pin_level: assert property ((config_word_o[2] && !config_word_o[4]) [*4]
    |-> !fast_settle_output_oe_n_o && fast_settle_output_o == config_word_o[3])
    else $error("pin level wrong");
  a_lock_routed: assert property ((!config_word_o[0] && lock_detect_i) [*4]
    |-> test_lock_output_o) else $error("lock detect not routed");
endmodule
bind synth_serial_load_port synth_port_checker u_chk (.clk_i(clk_i), .rstn_i(rstn_i),
  .load_strobe_i(load_strobe_i), .lock_detect_i(lock_detect_i), .config_word_o(config_word_o),
  .word_loaded_o(word_loaded_o), .fast_settle_output_o(fast_settle_output_o),
  .fast_settle_output_oe_n_o(fast_settle_output_oe_n_o),
  .test_lock_output_o(test_lock_output_o));
`default_nettype wire

// ===== synth_serial_load_port_test.sv
`timescale 1ns/1ps
`default_nettype none
module synth_serial_load_port_test;
  logic clk_i = 0, rstn_i = 0, rbe = 0, refc = 0, lock = 0, fsa = 0;
  logic ce = 1;
  int errors = 0, cmp_count = 0, n, tn, rn, wn;
  wire sclk, sdata, stb, wl, coe, rbo, fso, fsoe, tlo;
  wire [23:0] cw;
  initial forever #25 clk_i = ~clk_i;
  initial forever #65 refc = ~refc;
  always @(tlo) tn++;
  always @(rbo) rn++;
  always @(posedge wl) wn++;
  serial_host_model host (.sclk_o(sclk), .sdata_o(sdata), .load_strobe_o(stb));
  synth_serial_load_port dut (.clk_i(clk_i), .rstn_i(rstn_i), .sclk_i(sclk), .sdata_i(sdata),
    .load_strobe_i(stb), .chip_enable_i(ce), .ref_buffer_enable_i(rbe), .ref_clk_i(refc),
    .lock_detect_i(lock), .fast_settle_active_i(fsa), .config_word_o(cw), .word_loaded_o(wl),
    .core_enable_o(coe), .ref_buffer_output_o(rbo), .fast_settle_output_o(fso),
    .fast_settle_output_oe_n_o(fsoe), .test_lock_output_o(tlo));
  task chk(input logic [23:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task summarize;
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task load(input logic [23:0] w);
    wn = 0;
    @(posedge clk_i) #1 host.send(w);
    for (n = 0; n < 20 && cw !== w; n++) @(posedge clk_i);
    if (n == 20) errors++;
    repeat (3) @(posedge clk_i);
    #1 chk(cw, w);
    chk(wn, 1);
  endtask
  task t_fast_settle;
    load(24'h00000c);
    chk(fso, 1);
    chk(fsoe, 0);
    load(24'h000014);
    chk(fsoe, 1);
    load(24'h000020);
    @(posedge clk_i) #1 fsa = 1'b1;
    repeat (5) @(posedge clk_i);
    #1 chk({fso, fsoe}, 2'b10);
    fsa = 1'b0;
    repeat (5) @(posedge clk_i);
    #1 chk(fso, 0);
  endtask
  task t_lock;
    load(24'h000000);
    @(posedge clk_i) #1 lock = 1'b1;
    repeat (5) @(posedge clk_i);
    #1 chk(tlo, 1);
    load(24'h000001);
    tn = 0;
    repeat (40) @(posedge clk_i);
    chk(tn > 11, 1);
    load(24'h0000c1);
    tn = 0;
    repeat (40) @(posedge clk_i);
    chk(tn > 1 && tn < 6, 1);
  endtask
  task t_ref;
    load(24'h000002);
    chk(coe, 1);
    rn = 0;
    repeat (40) @(posedge clk_i);
    chk(rn > 4, 1);
    @(posedge clk_i) #1 ce = 1'b0;
    repeat (5) @(posedge clk_i);
    #1 chk(coe, 0);
    rn = 0;
    repeat (40) @(posedge clk_i);
    chk(rn, 0);
    @(posedge clk_i) #1 rbe = 1'b1;
    repeat (5) @(posedge clk_i);
    rn = 0;
    repeat (40) @(posedge clk_i);
    chk(rn > 4, 1);
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    #1 rstn_i = 1'b1;
    repeat (3) @(posedge clk_i);
    load(24'h96a5c3);
    t_fast_settle;
    t_lock;
    t_ref;
    summarize;
  end
endmodule
`default_nettype wire

// ===== word_latch.v
`timescale 1ns/1ps
`default_nettype none
`include "synth_port_map.vh"
module word_latch (
  // clock and reset
  input  wire                  clk_i,
  input  wire                  rstn_i,
  // load
  input  wire                  load_i,
  input  wire [`WORD_W-1:0]    word_i,
  output reg  [`WORD_W-1:0]    word_o
);
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      word_o <= `WORD_RST;
    end else if (load_i) begin
      word_o <= word_i;
    end
  end
endmodule
`default_nettype wire
